//--- pkg/gdd_params.svh
/*
  Constants of the gate drive input decoder: register offsets, field
  positions and reset values. Assumes inclusion by bare name.
*/
`ifndef GDD_PARAMS_SVH
`define GDD_PARAMS_SVH
`define GDD_ADDR_CTRL 4'h0
`define GDD_ADDR_STATUS 4'h1
`define GDD_ADDR_MASK 4'h2
`define GDD_ADDR_GATES 4'h3
`define GDD_CTRL_MODE_LSB 0
`define GDD_CTRL_EN_LSB 4
`define GDD_CTRL_RESET 8'h00
`define GDD_MASK_RESET 8'h00
`define GDD_EVT_SHOOT 0
`define GDD_EVT_FAULT 1
`define GDD_UNMAPPED_DATA 8'h00
`endif

//--- pkg/gdd_pkg.sv
/*
  Types of the gate drive input decoder.
  Assumes gdd_params.svh is available on the include path.
*/
package gdd_pkg;
  typedef enum logic [1:0] {
    GDD_MODE_6X,
    GDD_MODE_3X_PIN,
    GDD_MODE_3X_REG,
    GDD_MODE_SPARE
  } gdd_mode_type;
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } gdd_phase_type;
endpackage

//--- verilog/gdd_decoder.sv
/*
  Gate drive input decoder: per-phase command inputs to gate commands,
  with a small register port, sticky events and interrupt output.
  Assumes inputs synchronous to sys_clk; the serial link is outside.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
// Overview of operation
// - Three decoding schemes chosen by a software-written mode field; the spare code is off.
// - Six-input: per phase, one input drives its gate; both set is off.
// - Three-input pin mode: high input selects upper or lower gate.
// - Three-input pin mode: low-side input low forces both gates off.
// - Register-enable mode: cleared enable bit holds both gates off.
// - Register-enable mode ignores the low-side input pins.
// - Register-enable mode: high input chooses the driven gate.
// - Enable bits gate outputs in every scheme.
// - Detected faults drive the active-low fault indicator.
// - Controller configures and reads diagnostics; device is target.
`timescale 1ns/10ps
`include "gdd_params.svh"
module gdd_decoder
  import gdd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Phase command inputs and fault source
  input wire logic [2:0] phase_hi_cmd_in,
  input wire logic [2:0] phase_lo_cmd_in,
  input wire logic fault_event_in,
  // Gate outputs and indicators
  output logic [2:0] upper_gate_out,
  output logic [2:0] lower_gate_out,
  output logic fault_indicator_n,
  output logic irq
);

  logic [7:0] ctrl_q;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] mask_q;
  logic [7:0] event_d;
  gdd_phase_type gates_d;
  gdd_mode_type mode;
  logic [2:0] phase_drive_enable;

  assign mode = gdd_mode_type'(ctrl_q[`GDD_CTRL_MODE_LSB +: 2]);
  assign phase_drive_enable = ctrl_q[`GDD_CTRL_EN_LSB +: 3];

  // Decode one phase; returns {upper, lower}
  // Spare mode and a cleared enable both fall through to off
  function automatic logic [1:0] decode_phase(
    input gdd_mode_type m,
    input logic en,
    input logic hi,
    input logic lo
  );
    logic [1:0] r;
    r = 2'h0;
    if (en) begin
      case (m)
        GDD_MODE_6X: begin
          r = (hi & lo) ? 2'h0 : {hi, lo};
        end
        GDD_MODE_3X_PIN: begin
          r = lo ? {hi, ~hi} : 2'h0;
        end
        GDD_MODE_3X_REG: begin
          r = {hi, ~hi};
        end
        default: begin
          r = 2'h0;
        end
      endcase
    end
    return r;
  endfunction

  always_comb begin
    gates_d = '0;
    for (int i = 0; i < 3; i++) begin
      {gates_d.hi[i], gates_d.lo[i]} = decode_phase(mode,
        phase_drive_enable[i], phase_hi_cmd_in[i], phase_lo_cmd_in[i]);
    end
  end

  // Gate outputs registered, off after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      upper_gate_out <= 3'h0;
      lower_gate_out <= 3'h0;
    end else begin
      upper_gate_out <= gates_d.hi;
      lower_gate_out <= gates_d.lo;
    end
  end

  // Control register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q <= `GDD_CTRL_RESET;
    end else if (reg_wr && reg_addr == `GDD_ADDR_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mask_q <= `GDD_MASK_RESET;
    end else if (reg_wr && reg_addr == `GDD_ADDR_MASK) begin
      mask_q <= reg_wdata;
    end
  end

  // Events: shoot-through request seen, external fault
  // Shoot request is logged though its gates stay off
  always_comb begin
    event_d = 8'h00;
    event_d[`GDD_EVT_SHOOT] = (mode == GDD_MODE_6X) &&
      |(phase_hi_cmd_in & phase_lo_cmd_in);
    event_d[`GDD_EVT_FAULT] = fault_event_in;
    status_d = status_q;
    if (reg_rd && reg_addr == `GDD_ADDR_STATUS) begin
      status_d = 8'h00;
    end
    status_d = status_d | event_d; // Set wins over clear
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_d;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq <= 1'h0;
    end else begin
      irq <= |(status_d & mask_q);
    end
  end

  // Fault pin follows the sticky fault bit, set included
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fault_indicator_n <= 1'h1;
    end else begin
      fault_indicator_n <= ~status_d[`GDD_EVT_FAULT];
    end
  end

  // Read data, one cycle after the strobe
  // Zero outside read cycles keeps the bus quiet
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `GDD_ADDR_CTRL: reg_rdata <= ctrl_q;
        `GDD_ADDR_STATUS: reg_rdata <= status_q;
        `GDD_ADDR_MASK: reg_rdata <= mask_q;
        `GDD_ADDR_GATES: reg_rdata <= {2'h0, upper_gate_out,
          lower_gate_out};
        default: reg_rdata <= `GDD_UNMAPPED_DATA;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Gate decoding checks
  never_both_on_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (upper_gate_out & lower_gate_out) == 3'h0)
    else $error("upper and lower gate both on");

  shoot_block_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_6X |=>
    ((upper_gate_out | lower_gate_out) &
    $past(phase_hi_cmd_in) & $past(phase_lo_cmd_in)) == 3'h0)
    else $error("shoot-through not blocked");

  six_upper_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_6X |=> upper_gate_out ==
    ($past(phase_hi_cmd_in) & ~$past(phase_lo_cmd_in) &
    $past(phase_drive_enable)))
    else $error("six-input upper gate wrong");

  six_lower_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_6X |=> lower_gate_out ==
    (~$past(phase_hi_cmd_in) & $past(phase_lo_cmd_in) &
    $past(phase_drive_enable)))
    else $error("six-input lower gate wrong");

  pin_select_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (mode == GDD_MODE_3X_PIN &&
    phase_drive_enable[1] && phase_lo_cmd_in[1]) |=>
    upper_gate_out[1] == $past(phase_hi_cmd_in[1]) &&
    lower_gate_out[1] != $past(phase_hi_cmd_in[1]))
    else $error("pin mode selection wrong");

  pin_upper_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_3X_PIN |=> upper_gate_out ==
    ($past(phase_hi_cmd_in) & $past(phase_lo_cmd_in) &
    $past(phase_drive_enable)))
    else $error("pin mode upper gate wrong");

  pin_lower_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_3X_PIN |=> lower_gate_out ==
    (~$past(phase_hi_cmd_in) & $past(phase_lo_cmd_in) &
    $past(phase_drive_enable)))
    else $error("pin mode lower gate wrong");

  pin_off_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (mode == GDD_MODE_3X_PIN && !phase_lo_cmd_in[2])
    |=> !upper_gate_out[2] && !lower_gate_out[2])
    else $error("pin mode off state failed");

  reg_disable_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) ((upper_gate_out | lower_gate_out) &
    ~$past(phase_drive_enable)) == 3'h0)
    else $error("disabled phase drives a gate");

  reg_select_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (mode == GDD_MODE_3X_REG && phase_drive_enable[2])
    |=> lower_gate_out[2] == !$past(phase_hi_cmd_in[2]))
    else $error("register mode selection wrong");

  reg_upper_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_3X_REG |=> upper_gate_out ==
    ($past(phase_hi_cmd_in) & $past(phase_drive_enable)))
    else $error("register mode upper gate wrong");

  spare_off_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) mode == GDD_MODE_SPARE |=>
    (upper_gate_out | lower_gate_out) == 3'h0)
    else $error("spare mode drives a gate");

  // Register and event checks
  mode_write_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (reg_wr && reg_addr == `GDD_ADDR_CTRL) |=>
    ctrl_q == $past(reg_wdata))
    else $error("control write lost");

  mask_write_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (reg_wr && reg_addr == `GDD_ADDR_MASK) |=>
    mask_q == $past(reg_wdata))
    else $error("mask write lost");

  fault_pin_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) fault_event_in |=>
    !fault_indicator_n && status_q[`GDD_EVT_FAULT])
    else $error("fault not indicated");

  fault_release_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (!fault_event_in && reg_rd &&
    reg_addr == `GDD_ADDR_STATUS) |=> fault_indicator_n)
    else $error("fault indicator not released");

  status_clear_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (!fault_event_in && reg_rd &&
    reg_addr == `GDD_ADDR_STATUS) |=> !status_q[`GDD_EVT_FAULT])
    else $error("fault status not cleared");

  status_sticky_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (status_q[`GDD_EVT_FAULT] &&
    !(reg_rd && reg_addr == `GDD_ADDR_STATUS)) |=>
    status_q[`GDD_EVT_FAULT] && !fault_indicator_n)
    else $error("fault status lost");

  irq_level_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) irq == |($past(status_d) & $past(mask_q)))
    else $error("interrupt level wrong");

  rdata_idle_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  rdata_status_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (reg_rd && reg_addr == `GDD_ADDR_STATUS) |=>
    reg_rdata == $past(status_q))
    else $error("status read data wrong");

  rdata_unmapped_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (reg_rd && reg_addr > `GDD_ADDR_GATES) |=>
    reg_rdata == `GDD_UNMAPPED_DATA)
    else $error("unmapped read data wrong");

  // Scenario covers
  six_mode_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    mode == GDD_MODE_6X && |upper_gate_out);
  pin_mode_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    mode == GDD_MODE_3X_PIN && |lower_gate_out);
  reg_mode_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    mode == GDD_MODE_3X_REG && |upper_gate_out);
  irq_c: cover property (@(posedge sys_clk) disable iff (!rstn) irq);
  fault_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    !fault_indicator_n && status_q[`GDD_EVT_FAULT]);

endmodule

//--- testbench/gdd_ctrl_model.sv
/* Motor controller model driving the phase command and fault pins.
   Assumes the bench sets requests by NBA at sys_clk edges. */
`timescale 1ns/10ps
module gdd_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Bench requests
  input wire logic [2:0] hi_req,
  input wire logic [2:0] lo_req,
  input wire logic fault_req,
  // Device pins
  output logic [2:0] phase_hi_cmd_in,
  output logic [2:0] phase_lo_cmd_in,
  output logic fault_event_in
);
  // One process drives every pin
  initial begin
    phase_hi_cmd_in = 3'h0;
    phase_lo_cmd_in = 3'h7; // Idle low inputs held high
    fault_event_in = 1'h0;
    forever begin
      @(posedge sys_clk);
      phase_hi_cmd_in <= hi_req;
      phase_lo_cmd_in <= lo_req;
      fault_event_in <= fault_req;
    end
  end
endmodule

//--- testbench/testbench.sv
/* Self-checking bench of the gate drive input decoder.
   Assumes gdd_pkg and gdd_params.svh, one 100 MHz clock. */
`timescale 1ns/10ps
`include "gdd_params.svh"
module testbench;
  import gdd_pkg::*;
  logic sys_clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic fault_req = 1'h0, fev, fault_indicator_n, irq;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [2:0] hi_req = 3'h0, lo_req = 3'h7, ph_hi, ph_lo, up, lw;
  int failures = 0, check_count = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  gdd_ctrl_model PM (.sys_clk(sys_clk), .hi_req(hi_req), .lo_req(lo_req),
    .fault_req(fault_req), .phase_hi_cmd_in(ph_hi),
    .phase_lo_cmd_in(ph_lo), .fault_event_in(fev));
  gdd_decoder DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .phase_hi_cmd_in(ph_hi),
    .phase_lo_cmd_in(ph_lo), .fault_event_in(fev),
    .upper_gate_out(up), .lower_gate_out(lw),
    .fault_indicator_n(fault_indicator_n), .irq(irq));
  task automatic close_out;
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  function automatic logic [7:0] gexp(logic [1:0] m, logic [2:0] e, h, l);
    logic [2:0] u, w;
    u = (m == GDD_MODE_6X) ? h & ~l : (m == GDD_MODE_3X_PIN) ? h & l :
      (m == GDD_MODE_3X_REG) ? h : 3'h0;
    w = (m == GDD_MODE_6X) ? l & ~h : (m == GDD_MODE_3X_PIN) ? ~h & l :
      (m == GDD_MODE_3X_REG) ? ~h : 3'h0;
    return {2'h0, u & e, w & e};
  endfunction
  task automatic reset_state;
    #1 chk({up, lw, fault_indicator_n, irq}, 8'h02);
    rd(`GDD_ADDR_CTRL, d);
    chk(d, `GDD_CTRL_RESET);
    rd(`GDD_ADDR_MASK, d);
    chk(d, `GDD_MASK_RESET);
  endtask
  task automatic gate_sweep;
    logic [5:0] v;
    logic [7:0] x;
    for (int m = 0; m < 4; m++) begin
      for (int e = 5; e < 8; e = e + 2) begin
        wr(`GDD_ADDR_CTRL, {1'h0, e[2:0], 2'h0, m[1:0]});
        for (int i = 0; i < 64; i++) begin
          v = i[5:0];
          @(posedge sys_clk);
          hi_req <= v[2:0];
          lo_req <= v[5:3];
          repeat (3) @(posedge sys_clk);
          x = gexp(m[1:0], e[2:0], v[2:0], v[5:3]);
          #1 chk({2'h0, up, lw}, x);
        end
      end
    end
  endtask
  task automatic events_irq;
    rd(`GDD_ADDR_STATUS, d);
    wr(`GDD_ADDR_CTRL, 8'h70);
    hi_req <= 3'h1;
    lo_req <= 3'h1;
    repeat (3) @(posedge sys_clk);
    hi_req <= 3'h1;
    lo_req <= 3'h2;
    fault_req <= 1'h1;
    @(posedge sys_clk);
    fault_req <= 1'h0;
    repeat (3) @(posedge sys_clk);
    #1 chk({fault_indicator_n, irq}, 8'h00);
    wr(`GDD_ADDR_MASK, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 8'h01);
    wr(`GDD_ADDR_GATES, 8'hFF);
    rd(`GDD_ADDR_GATES, d);
    chk(d, 8'h0A);
    rd(4'hF, d);
    chk(d, `GDD_UNMAPPED_DATA);
    rd(`GDD_ADDR_STATUS, d);
    chk(d, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk({fault_indicator_n, irq}, 8'h02);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'h1;
    reset_state();
    gate_sweep();
    events_irq();
    close_out();
  end
endmodule
